// *** rtl/ccsi_top.sv ***
`default_nettype none

module ccsi_top
  import ccsi_pkg::*;
#(
  // version codes: values are arbitrary
  parameter logic [2:0] VER_DEVICE = 3'h1,
  parameter logic [2:0] VER_DIGEST = 3'h1,
  parameter logic [2:0] VER_DES    = 3'h1,
  parameter logic [2:0] VER_ARC4   = 3'h1,
  parameter logic [2:0] VER_RAND   = 3'h1,
  parameter logic [2:0] VER_HOSTBC = 3'h1,
  parameter logic [2:0] VER_PKEY   = 3'h1
) (
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  arst_n,
  // host register port
  input  wire ccsi_req_type          host_req,
  output logic [31:0]                host_rdata,
  output logic                       host_rvalid,
  // execution unit events
  input  wire logic [UNIT_COUNT-1:0] unit_irq,
  input  wire logic [UNIT_COUNT-1:0] unit_done,
  input  wire logic [UNIT_COUNT-1:0] unit_busy,
  // buffer traffic and internal access
  input  wire logic                  buf_req,
  input  wire logic                  unit_acc_req,
  output logic [UNIT_COUNT-1:0]      unit_buf_sel,
  output logic [UNIT_COUNT-1:0]      unit_buf_req,
  output logic                       unit_acc_grant,
  // host interrupt and device reset
  output logic                       irq_n,
  output logic                       dev_rst_n
);

  localparam logic [31:0] ID_VALUE = {VER_PKEY, VER_HOSTBC, ID_RSVD_HI, VER_RAND, VER_ARC4,
                                      VER_DES, VER_DIGEST, VER_DEVICE, ID_RSVD_LO};

  function automatic logic [UNIT_COUNT-1:0] dest_decode(input logic [3:0] code);
    logic [UNIT_COUNT-1:0] sel;
    sel = '0;
    if (code == DEST_DES) begin
      sel[U_DES] = 1'b1;
    end else if (code == DEST_ARC4) begin
      sel[U_ARC4] = 1'b1;
    end else if (code == DEST_DIGEST) begin
      sel[U_DIGEST] = 1'b1;
    end else if (code == DEST_RAND) begin
      sel[U_RAND] = 1'b1;
    end else if (code == DEST_PKEY) begin
      sel[U_PKEY] = 1'b1;
    end
    return sel;
  endfunction : dest_decode

  logic                  rst_sync_n;
  logic [3:0]            dest_r;
  logic [2:0]            auto_r;
  logic                  soft_rst_r;
  logic [UNIT_COUNT-1:0] mask_r;
  logic [UNIT_COUNT-1:0] mask_nxt;
  logic [UNIT_COUNT-1:0] unmask_clr;
  logic [UNIT_COUNT-1:0] passed_irq;
  logic                  wr_status;
  logic                  wr_mask;
  logic                  rd_en;
  logic [31:0]           status_view;
  logic [31:0]           rdata_nxt;

  ccsi_rst_sync i_ccsi_rst_sync (
    .clock      (clock),
    .arst_n     (arst_n),
    .rst_sync_n (rst_sync_n)
  );

  assign wr_status = host_req.cs && host_req.we && (host_req.addr == STATUS_ADDR);
  assign wr_mask   = host_req.cs && host_req.we && (host_req.addr == MASK_ADDR);
  assign rd_en     = host_req.cs && !host_req.we;

  // destination, auto-unmask and soft reset
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      dest_r     <= DEST_RST;
      auto_r     <= AUTO_OFF;
      soft_rst_r <= 1'b0;
    end else if (soft_rst_r) begin
      // destination, auto-unmask, mask and the soft reset bit clear on the edge after the write
      dest_r     <= DEST_RST;
      auto_r     <= AUTO_OFF;
      soft_rst_r <= 1'b0;
    end else if (wr_status) begin
      dest_r     <= host_req.wdata[DEST_LSB+:4];
      auto_r     <= host_req.wdata[AUTO_LSB+:3];
      soft_rst_r <= host_req.wdata[SRST_BIT];
    end
  end

  assign unit_buf_sel = dest_decode(dest_r);
  assign unit_buf_req = unit_buf_sel & {UNIT_COUNT{buf_req}};
  // unit internals stay closed while the selected unit executes
  assign unit_acc_grant = unit_acc_req && !(|(unit_busy & unit_buf_sel));

  // hardware unmask wins over a host mask write in the same cycle
  assign unmask_clr = (auto_r == AUTO_ON) ? (unit_done & unit_buf_sel) : '0;

  always_comb begin
    mask_nxt = mask_r;
    if (wr_mask) begin
      mask_nxt = host_req.wdata[MASK_LSB+:UNIT_COUNT];
    end
    mask_nxt = mask_nxt & ~unmask_clr;
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mask_r <= MASK_RST;
    end else if (soft_rst_r) begin
      mask_r <= MASK_RST;
    end else begin
      mask_r <= mask_nxt;
    end
  end

  assign passed_irq = unit_irq & ~mask_r;

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= !(|passed_irq);
    end
  end

  always_comb begin
    status_view                        = '0;
    status_view[RAW_LSB+:UNIT_COUNT]   = unit_irq;
    status_view[PEND_BIT]              = |unit_irq;
    status_view[DEST_LSB+:4]           = dest_r;
    status_view[AUTO_LSB+:3]           = auto_r;
    status_view[SRST_BIT]              = soft_rst_r;
  end

  always_comb begin
    rdata_nxt = '0;
    if (host_req.addr == STATUS_ADDR) begin
      rdata_nxt = status_view;
    end else if (host_req.addr == ID_ADDR) begin
      rdata_nxt = ID_VALUE;
    end else if (host_req.addr == MASK_ADDR) begin
      rdata_nxt[MASK_LSB+:UNIT_COUNT] = mask_r;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      host_rdata  <= '0;
      host_rvalid <= 1'b0;
    end else begin
      host_rvalid <= rd_en;
      if (rd_en) begin
        host_rdata <= rdata_nxt;
      end
    end
  end

  assign dev_rst_n = rst_sync_n && !soft_rst_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_sync_n);

  irq_assert_a: assert property (!soft_rst_r && |(unit_irq & ~mask_r) |=> !irq_n)
    else $error("unmasked interrupt did not pull the pin low");
  irq_negate_a: assert property (!(|(unit_irq & ~mask_r)) |=> irq_n)
    else $error("interrupt pin low with nothing pending");
  raw_read_a: assert property (rd_en && host_req.addr == STATUS_ADDR |=>
                               host_rvalid && host_rdata[22:18] == $past(unit_irq))
    else $error("raw interrupt bits wrong on read");
  pend_read_a: assert property (rd_en && host_req.addr == STATUS_ADDR |=>
                                host_rdata[PEND_BIT] == $past(|unit_irq))
    else $error("pending bit wrong on read");
  rsvd_zero_a: assert property (rd_en && host_req.addr == STATUS_ADDR |=>
                                host_rdata[17:0] == 18'h00000)
    else $error("reserved status bits not zero");
  dest_pick_a: assert property (!soft_rst_r && wr_status &&
                                host_req.wdata[27:24] == 4'hA |=> unit_buf_sel == 5'b00100)
    else $error("digest code did not select digest unit");
  no_unit_a: assert property (!dest_r[3] |-> unit_buf_req == 5'b00000)
    else $error("buffer traffic with no unit selected");
  one_unit_a: assert property ($onehot0(unit_buf_sel))
    else $error("more than one unit selected");
  auto_clear_a: assert property (!soft_rst_r && auto_r == 3'h1 &&
                                 |(unit_done & unit_buf_sel) |=>
                                 (mask_r & $past(unit_buf_sel)) == 5'b00000)
    else $error("active unit mask not cleared on completion");
  auto_off_a: assert property (auto_r != 3'h1 && !wr_mask && !soft_rst_r |=> $stable(mask_r))
    else $error("mask changed while auto-unmask off");
  soft_rst_a: assert property (!soft_rst_r && wr_status && host_req.wdata[31] |=>
                               soft_rst_r && !dev_rst_n ##1 !soft_rst_r && dest_r == 4'h0)
    else $error("soft reset did not act and self-clear");
  id_read_a: assert property (rd_en && host_req.addr == 12'h901 |=>
                              host_rdata == ID_VALUE && host_rdata[7:0] == 8'h00)
    else $error("identification read wrong");
  busy_block_a: assert property (|(unit_busy & unit_buf_sel) |-> !unit_acc_grant)
    else $error("internal access granted during execution");

  rvalid_pulse_a: assert property (!rd_en |=> !host_rvalid)
    else $error("read valid without a read strobe");
  rdata_hold_a: assert property (!rd_en |=> $stable(host_rdata))
    else $error("read data changed without a read");
  mask_write_a: assert property (!soft_rst_r && wr_mask && unmask_clr == 5'b00000 |=>
                                 mask_r == $past(host_req.wdata[31:27]))
    else $error("mask write did not land");
  status_write_a: assert property (!soft_rst_r && wr_status |=>
                                   dest_r == $past(host_req.wdata[27:24]))
    else $error("destination write did not land");
  soft_clear_a: assert property (soft_rst_r |=> mask_r == 5'b00000 && auto_r == 3'h0)
    else $error("soft reset left mask or auto-unmask set");
  soft_pin_a: assert property (soft_rst_r |-> !dev_rst_n)
    else $error("device reset not driven during soft reset");
  route_pkey_a: assert property (buf_req && dest_r == 4'hC |-> unit_buf_req == 5'b10000)
    else $error("buffer traffic missed the public key unit");

  soft_rst_c: cover property (wr_status && host_req.wdata[31] ##1 soft_rst_r);
  auto_unmask_c: cover property (|unmask_clr ##1 !irq_n);
  id_read_c: cover property (rd_en && host_req.addr == ID_ADDR ##1 host_rvalid);
  irq_cycle_c: cover property (!irq_n ##[1:20] irq_n);

endmodule : ccsi_top

`default_nettype wire

// *** rtl/ccsi_pkg.sv ***
// Notes on behaviour
// - Bits 20, 21, 22 show the raw digest, random source and public key interrupts.
// - Bits 18 to 22 show each unit interrupt before masking; 1 means pending.
// - Bit 23 is set while any unit interrupt is pending, else clear.
// - Bits 24 to 27 select the active unit; top bit 0 selects none.
// - Only the selected unit is served by buffer traffic; host picks it.
// - With auto-unmask on, the active unit's mask clears when it finishes.
// - Auto-unmask field 000 means off, 001 means on.
// - Writing 1 to bit 31 resets the device within two cycles, then self-clears.
// - Host may use registers and buffers during execution, never unit internals; the code blocks internal access only while the selected unit is busy.
// - Read-only 32-bit identification register at address 0x901, reset value fixed.
// - Identification holds 3-bit versions in fixed fields; other bits are reserved.
// - A unit interrupt reaches the host pin only while its mask bit is 0.
// - The active-low interrupt pin stays low until no unmasked interrupt remains.
`default_nettype none

package ccsi_pkg;

  localparam int          UNIT_COUNT  = 5;
  localparam int          ADDR_WIDTH  = 12;
  // unit index order
  localparam int          U_DES       = 0;
  localparam int          U_ARC4      = 1;
  localparam int          U_DIGEST    = 2;
  localparam int          U_RAND      = 3;
  localparam int          U_PKEY      = 4;

  localparam logic [11:0] STATUS_ADDR = 12'h900;
  localparam logic [11:0] ID_ADDR     = 12'h901;
  localparam logic [11:0] MASK_ADDR   = 12'h902;

  localparam int          RAW_LSB     = 18;
  localparam int          PEND_BIT    = 23;
  localparam int          DEST_LSB    = 24;
  localparam int          AUTO_LSB    = 28;
  localparam int          SRST_BIT    = 31;
  localparam int          MASK_LSB    = 27;

  localparam logic [3:0]  DEST_DES    = 4'h8;
  localparam logic [3:0]  DEST_ARC4   = 4'h9;
  localparam logic [3:0]  DEST_DIGEST = 4'hA;
  localparam logic [3:0]  DEST_RAND   = 4'hB;
  localparam logic [3:0]  DEST_PKEY   = 4'hC;
  localparam logic [3:0]  DEST_RST    = 4'h0;

  localparam logic [2:0]  AUTO_OFF    = 3'h0;
  localparam logic [2:0]  AUTO_ON     = 3'h1;
  localparam logic [4:0]  MASK_RST    = 5'h00;
  localparam logic [7:0]  ID_RSVD_LO  = 8'h00;
  localparam logic [2:0]  ID_RSVD_HI  = 3'h0;

  typedef struct packed {
    logic        cs;
    logic        we;
    logic [11:0] addr;
    logic [31:0] wdata;
  } ccsi_req_type;

endpackage : ccsi_pkg

`default_nettype wire

// *** rtl/ccsi_rst_sync.sv ***
`default_nettype none

// releases the pin reset through two flip-flops
module ccsi_rst_sync (
  input  wire logic clock,
  input  wire logic arst_n,
  output logic      rst_sync_n
);

  logic meta_r;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      meta_r     <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      meta_r     <= 1'b1;
      rst_sync_n <= meta_r;
    end
  end

endmodule : ccsi_rst_sync

`default_nettype wire

// *** tb/ccsi_unit_model.sv ***
`default_nettype none

module ccsi_unit_model
  import ccsi_pkg::*;
(
  // clock and device reset
  input  wire logic                  clock,
  input  wire logic                  dev_rst_n,
  // controller side of the units
  input  wire logic [UNIT_COUNT-1:0] unit_buf_req,
  output logic      [UNIT_COUNT-1:0] unit_irq,
  output logic      [UNIT_COUNT-1:0] unit_done,
  output logic      [UNIT_COUNT-1:0] unit_busy
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    unit_irq  = '0;
    unit_done = '0;
  end

  // a unit runs once buffer traffic reaches it, and stops when it reports done
  always_ff @(posedge clock) begin
    if (!dev_rst_n) begin
      unit_busy <= '0;
    end else begin
      unit_busy <= (unit_busy | unit_buf_req) & ~unit_done;
    end
  end

  task automatic raise(input logic [UNIT_COUNT-1:0] v);
    @(posedge clock);
    unit_irq <= v;
  endtask : raise

  task automatic finish(input int u);
    @(posedge clock);
    unit_done[u] <= 1'b1;
    @(posedge clock);
    unit_done[u] <= 1'b0;
  endtask : finish
endmodule : ccsi_unit_model

`default_nettype wire

// *** tb/tb_crypto_control_status_and_id.sv ***
`default_nettype none

module tb_crypto_control_status_and_id
  import ccsi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [31:0] ID_EXP = {3'h7, 3'h6, 3'h0, 3'h1, 3'h4, 3'h3, 3'h2, 3'h1, 8'h00};
  logic                  clock, arst_n, buf_req, unit_acc_req;
  logic                  host_rvalid, unit_acc_grant, irq_n, dev_rst_n;
  ccsi_req_type          host_req;
  logic [31:0]           host_rdata;
  logic [UNIT_COUNT-1:0] unit_irq, unit_done, unit_busy, unit_buf_sel, unit_buf_req;
  int                    n_fail, checks, cycles;
  logic [3:0]            codes [6] = '{4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'h3};
  logic [4:0]            sels  [6] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h00};

  // version values are arbitrary; device and random source keep the default
  ccsi_top #(.VER_DIGEST(3'h2), .VER_DES(3'h3), .VER_ARC4(3'h4), .VER_HOSTBC(3'h6),
             .VER_PKEY(3'h7)) i_ccsi_top (
    .clock(clock), .arst_n(arst_n), .host_req(host_req), .host_rdata(host_rdata),
    .host_rvalid(host_rvalid), .unit_irq(unit_irq), .unit_done(unit_done),
    .unit_busy(unit_busy), .buf_req(buf_req), .unit_acc_req(unit_acc_req),
    .unit_buf_sel(unit_buf_sel), .unit_buf_req(unit_buf_req),
    .unit_acc_grant(unit_acc_grant), .irq_n(irq_n), .dev_rst_n(dev_rst_n));

  ccsi_unit_model i_ccsi_unit_model (
    .clock(clock), .dev_rst_n(dev_rst_n), .unit_buf_req(unit_buf_req),
    .unit_irq(unit_irq), .unit_done(unit_done), .unit_busy(unit_busy));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic conclude();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      n_fail = n_fail + 1;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    host_req <= '{cs: 1'b1, we: 1'b1, addr: a, wdata: d};
    @(posedge clock);
    host_req.cs <= 1'b0;
    #1;
  endtask : wr

  // the strobe is taken at the second edge; the answer stands just after that same edge
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clock);
    host_req <= '{cs: 1'b1, we: 1'b0, addr: a, wdata: 32'h0};
    @(posedge clock);
    host_req.cs <= 1'b0;
    #1;
    chk({31'h0, host_rvalid}, 32'h1);
    chk(host_rdata, exp);
  endtask : rd_chk

  task automatic irq_chk(input logic exp);
    @(posedge clock);
    #1;
    chk({31'h0, irq_n}, {31'h0, exp});
  endtask : irq_chk

  initial begin
    host_req = '0;
    buf_req = 1'b0;
    unit_acc_req = 1'b0;
    arst_n = 1'b0;
    n_fail = 0;
    checks = 0;
    cycles = 0;
    repeat (5) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    rd_chk(ID_ADDR, ID_EXP);
    wr(ID_ADDR, 32'hFFFF_FFFF);
    rd_chk(ID_ADDR, ID_EXP);
    rd_chk(12'h905, 32'h0);
    rd_chk(STATUS_ADDR, 32'h0);
    @(posedge clock);
    buf_req <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      wr(STATUS_ADDR, {4'h0, codes[i], 24'hFF_FFFF});
      rd_chk(STATUS_ADDR, {4'h0, codes[i], 24'h0});
      chk({22'h0, unit_buf_sel, unit_buf_req}, {22'h0, sels[i], sels[i]});
    end
    wr(MASK_ADDR, 32'hF800_0000);
    wr(STATUS_ADDR, 32'h8C00_0000);
    chk({31'h0, dev_rst_n}, 32'h0);
    @(posedge clock);
    buf_req <= 1'b0;
    rd_chk(STATUS_ADDR, 32'h0);
    rd_chk(MASK_ADDR, 32'h0);
    wr(STATUS_ADDR, 32'h0800_0000);
    @(posedge clock);
    unit_acc_req <= 1'b1;
    buf_req <= 1'b1;
    @(posedge clock);
    buf_req <= 1'b0;
    #1;
    chk({31'h0, unit_acc_grant}, 32'h0);
    i_ccsi_unit_model.finish(0);
    #1;
    chk({31'h0, unit_acc_grant}, 32'h1);
    i_ccsi_unit_model.raise(5'h05);
    irq_chk(1'b0);
    rd_chk(STATUS_ADDR, 32'h0894_0000);
    wr(MASK_ADDR, 32'hFFFF_FFFF);
    irq_chk(1'b1);
    rd_chk(MASK_ADDR, 32'hF800_0000);
    wr(MASK_ADDR, 32'h2000_0000);
    irq_chk(1'b0);
    i_ccsi_unit_model.raise(5'h04);
    irq_chk(1'b1);
    wr(STATUS_ADDR, 32'h1A00_0000);
    i_ccsi_unit_model.finish(2);
    irq_chk(1'b0);
    rd_chk(MASK_ADDR, 32'h0);
    wr(MASK_ADDR, 32'h2000_0000);
    wr(STATUS_ADDR, 32'h0A00_0000);
    i_ccsi_unit_model.finish(2);
    irq_chk(1'b1);
    // auto-unmask codes other than 001 act as off but read back
    wr(STATUS_ADDR, 32'h2A00_0000);
    i_ccsi_unit_model.finish(2);
    irq_chk(1'b1);
    rd_chk(STATUS_ADDR, 32'h2A90_0000);
    rd_chk(MASK_ADDR, 32'h2000_0000);
    conclude();
  end
endmodule : tb_crypto_control_status_and_id

`default_nettype wire
